/* File: hdl/bsc_pkg.sv */
// package: constants, enums and structs for the b-slice skip/direct converter
package bsc_pkg;

	// mb_type symbol values as coded in the bitstream
	localparam logic [4:0] BSC_MBTYPE_DIRECT  = 5'h00; // b_direct_16x16 (b slice)
	localparam logic [4:0] BSC_MBTYPE_P_L0    = 5'h00; // p_l0_16x16 (p slice)
	localparam logic [4:0] BSC_MBTYPE_B8X8    = 5'h16; // b_8x8 / bp_8x8 input code
	// sub-shape codes for skip/direct inputs
	localparam logic [7:0] BSC_SHAPE_8X8      = 8'h00; // four_vector_pairs
	localparam logic [7:0] BSC_SHAPE_4X4      = 8'hff; // sixteen_vector_pairs
	localparam logic [3:0] BSC_DIRECT_ALL     = 4'hf;  // all four sub-blocks direct
	// reset values
	localparam logic       BSC_RST_FLAG       = 1'b0;
	localparam logic [4:0] BSC_RST_TYPE       = 5'h00;

	// decision classes of the input macroblock
	typedef enum logic [1:0] {
		BSC_IN_SKIP   = 2'b00,
		BSC_IN_DIRECT = 2'b01,
		BSC_IN_OTHER  = 2'b10
	} bsc_class_e;

	// pair position state
	typedef enum logic [0:0] {
		BSC_PAIR_TOP = 1'b0,
		BSC_PAIR_BOT = 1'b1
	} bsc_pair_e;

	// one input macroblock from mode decision
	typedef struct packed {
		logic       skip_hint;      // input mb skip flag
		logic [4:0] mb_type;        // input mb type
		logic [3:0] direct_pattern; // direct 8x8 pattern
		logic [7:0] sub_shape;      // sub-macroblock shape
		logic [5:0] cbp_in;         // input cbp (y4, cb, cr)
		logic       per_block_off;  // per_block_skip_conversion_off
		logic       pair_field_flag;
	} bsc_mb_s;

	// neighbour pair status
	typedef struct packed {
		logic avail_a;
		logic field_a;
		logic avail_b;
		logic field_b;
	} bsc_nbr_s;

	// decision result
	typedef struct packed {
		logic       mb_skip_flag;
		logic [4:0] mb_type;
		logic [5:0] coded_block_pattern;
		logic       pair_skip_permitted;
		logic       sub_individual;  // sub-blocks coded one by one
	} bsc_out_s;

endpackage : bsc_pkg

/* File: hdl/bsc_pair_permit.sv */
// pair skip permission tracker for mbaff macroblock pairs
`timescale 1ns/10ps
module bsc_pair_permit
	import bsc_pkg::*;
(
	input  wire logic     clk_i,        // packer clock
	input  wire logic     rst_n_i,      // synchronised reset, active low
	input  wire logic     slice_start_i,// clears pair state
	input  wire logic     mbaff_i,      // mbaff operation
	input  wire logic     mb_valid_i,   // current macroblock decided this cycle
	input  wire logic     field_i,      // pair_field_flag of current pair
	input  wire bsc_nbr_s nbr_i,        // neighbour pair status
	input  wire logic     coded_skip_i, // current macroblock coded as skip
	output logic          permit_o      // pair_skip_permitted, combinational
);

	bsc_pair_e pos_q;
	logic      first_skip_q;
	logic      nbr_ok;

	// neighbour condition: a, else b, else field flag zero
	always_comb begin
		if (nbr_i.avail_a)
			nbr_ok = (field_i == nbr_i.field_a);
		else if (nbr_i.avail_b)
			nbr_ok = (field_i == nbr_i.field_b);
		else
			nbr_ok = (field_i == 1'b0);
	end

	// permission: always on outside mbaff and for the top macroblock
	always_comb begin
		if (!mbaff_i)
			permit_o = 1'b1;
		else if (pos_q == BSC_PAIR_TOP)
			permit_o = 1'b1;
		else
			permit_o = !(first_skip_q && !nbr_ok);
	end

	// pair position and first-macroblock skip outcome
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pos_q        <= BSC_PAIR_TOP;
			first_skip_q <= 1'b0;
		end else if (slice_start_i) begin
			pos_q        <= BSC_PAIR_TOP;
			first_skip_q <= 1'b0;
		end else if (mb_valid_i && mbaff_i) begin
			if (pos_q == BSC_PAIR_TOP) begin
				pos_q        <= BSC_PAIR_BOT;
				first_skip_q <= coded_skip_i;
			end else begin
				pos_q        <= BSC_PAIR_TOP;
				first_skip_q <= 1'b0;
			end
		end
	end

endmodule : bsc_pair_permit

/* File: hdl/bsc_convert.sv */
// macroblock skip/direct conversion decision for the bitstream packer
`timescale 1ns/10ps
module bsc_convert
	import bsc_pkg::*;
#(
	parameter int CBP_W = 6 // coded block pattern width
)(
	input  wire logic             mclk_i,                      // packer clock
	input  wire logic             nrst_i,                      // async reset, active low
	input  wire logic             slice_start_i,               // first cycle of a slice
	input  wire logic             b_slice_i,                   // 1 b slice, 0 p slice
	input  wire logic             mbaff_i,                     // mbaff operation
	input  wire logic             slice_skip_conversion_off_i, // slice skip disable
	input  wire logic             slice_direct_conversion_off_i, // slice direct disable
	input  wire logic             mb_valid_i,                  // macroblock present
	input  wire bsc_mb_s          mb_i,                        // macroblock fields
	input  wire bsc_nbr_s         nbr_i,                       // neighbour pair status
	input  wire logic [CBP_W-1:0] cbp_quant_i,                 // cbp after quantisation
	input  wire logic             mv_match_i,                  // mv equals predictor (p)
	output logic                  out_valid_o,                 // decision valid pulse
	output bsc_out_s              out_o                        // decision
);

	logic             rst_m_q;
	logic             rst_n_q;
	bsc_class_e       cls;
	logic             permit;
	logic             skip_block;
	logic [CBP_W-1:0] cbp_eff;
	logic             dec_skip;
	logic [4:0]       dec_type;
	logic [CBP_W-1:0] dec_cbp;
	logic             dec_indiv;

	// reset release synchroniser
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// final cbp: quantised result masked by input pattern
	assign cbp_eff = cbp_quant_i & mb_i.cbp_in[CBP_W-1:0];

	// skip blocked by slice or per-macroblock control
	assign skip_block = slice_skip_conversion_off_i | mb_i.per_block_off;

	// classify input: skip hint, direct (b_8x8 all-direct with known shape), other
	always_comb begin
		if (mb_i.skip_hint)
			cls = BSC_IN_SKIP;
		else if (b_slice_i && mb_i.mb_type == BSC_MBTYPE_B8X8
				&& mb_i.direct_pattern == BSC_DIRECT_ALL
				&& (mb_i.sub_shape == BSC_SHAPE_8X8 || mb_i.sub_shape == BSC_SHAPE_4X4))
			cls = BSC_IN_DIRECT;
		else
			cls = BSC_IN_OTHER;
	end

	// pair permission tracking
	bsc_pair_permit u_pair (
		.clk_i        (mclk_i),
		.rst_n_i      (rst_n_q),
		.slice_start_i(slice_start_i),
		.mbaff_i      (mbaff_i),
		.mb_valid_i   (mb_valid_i),
		.field_i      (mb_i.pair_field_flag),
		.nbr_i        (nbr_i),
		.coded_skip_i (dec_skip),
		.permit_o     (permit)
	);

	// conversion table; b-slice skip/direct never checks mv (no vector derivation)
	always_comb begin
		dec_skip  = 1'b0;
		dec_type  = mb_i.mb_type;
		dec_cbp   = cbp_eff;
		dec_indiv = 1'b0;
		case (cls)
			BSC_IN_SKIP: begin
				dec_cbp = '0;
				if (permit) begin
					dec_skip = 1'b1;
					dec_type = BSC_RST_TYPE;
				end else if (b_slice_i) begin
					dec_type = BSC_MBTYPE_DIRECT;
				end else begin
					dec_type = BSC_MBTYPE_P_L0;
				end
			end
			BSC_IN_DIRECT: begin
				if (slice_direct_conversion_off_i) begin
					dec_type  = BSC_MBTYPE_B8X8;
					dec_indiv = 1'b1;
				end else if (cbp_eff != '0) begin
					dec_type = BSC_MBTYPE_DIRECT;
				end else if (skip_block) begin
					dec_type = BSC_MBTYPE_DIRECT;
				end else if (permit) begin
					dec_skip = 1'b1;
					dec_type = BSC_RST_TYPE;
				end else begin
					dec_type = BSC_MBTYPE_DIRECT;
				end
			end
			BSC_IN_OTHER: begin
				// p slice l0 16x16 may become p_skip; unforced denial just keeps type
				if (!b_slice_i && mb_i.mb_type == BSC_MBTYPE_P_L0 && !skip_block
						&& cbp_eff == '0 && mv_match_i && permit)
					dec_skip = 1'b1;
			end
			default: begin
				dec_skip = 1'b0;
			end
		endcase
	end

	// registered decision, one per macroblock in arrival order
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			out_valid_o <= 1'b0;
			out_o       <= '0;
		end else begin
			out_valid_o <= mb_valid_i;
			if (mb_valid_i) begin
				out_o.mb_skip_flag        <= dec_skip;
				out_o.mb_type             <= dec_type;
				out_o.coded_block_pattern                 <= 6'(dec_cbp);
				out_o.pair_skip_permitted <= permit;
				out_o.sub_individual      <= dec_indiv;
			end
		end
	end

endmodule : bsc_convert

/* File: tb/bsc_sva.sv */
// assertions for the b-slice skip/direct converter
`timescale 1ns/10ps
module bsc_sva
	import bsc_pkg::*;
#(
	parameter int CBP_W = 6 // cbp width
)(
	input	wire logic		mclk_i,	// clock
	input	wire logic		nrst_i,	// reset
	input	wire logic		slice_start_i,	// slice start
	input	wire logic		b_slice_i,	// b slice
	input	wire logic		mbaff_i,	// mbaff
	input	wire logic		slice_skip_conversion_off_i,	// skip off
	input	wire logic		slice_direct_conversion_off_i,	// direct off
	input	wire logic		mb_valid_i,	// strobe
	input	wire bsc_mb_s		mb_i,	// macroblock
	input	wire bsc_nbr_s		nbr_i,	// neighbours
	input	wire logic [CBP_W-1:0]	cbp_quant_i,	// cbp
	input	wire logic		out_valid_o,	// pulse
	input	wire bsc_out_s		out_o	// decision
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	// direct input, effective cbp, skip blocking
	wire shp = mb_i.sub_shape == BSC_SHAPE_8X8 || mb_i.sub_shape == BSC_SHAPE_4X4;
	wire dir = mb_valid_i && b_slice_i && !mb_i.skip_hint && mb_i.direct_pattern == BSC_DIRECT_ALL
		&& mb_i.mb_type == BSC_MBTYPE_B8X8 && shp;
	wire nz = |(cbp_quant_i & mb_i.cbp_in);
	wire off = slice_skip_conversion_off_i || mb_i.per_block_off;
	wire dco = slice_direct_conversion_off_i;
	// first macroblock of an mbaff b slice, forced skip
	sequence top_skip;
		slice_start_i ##2 (mb_valid_i && mbaff_i && b_slice_i && mb_i.skip_hint);
	endsequence
	chk_valid_pulse: assert property (out_valid_o == $past(mb_valid_i)) else $error("pulse");
	chk_skip_forced: assert property (mb_valid_i && b_slice_i && mb_i.skip_hint && !mbaff_i
		|=> out_o.mb_skip_flag && out_o.coded_block_pattern == 6'h00) else $error("skip");
	chk_flat_permit: assert property (mb_valid_i && !mbaff_i |=> out_o.pair_skip_permitted)
		else $error("permit");
	chk_keep_b8x8: assert property (dir && dco |=> !out_o.mb_skip_flag && out_o.sub_individual
		&& out_o.mb_type == BSC_MBTYPE_B8X8) else $error("b8x8");
	chk_direct_nz: assert property (dir && !dco && nz |=> !out_o.mb_skip_flag
		&& out_o.coded_block_pattern != 6'h00 && out_o.mb_type == BSC_MBTYPE_DIRECT) else $error("nz");
	chk_skip_blocked: assert property (dir && !dco && off |=> !out_o.mb_skip_flag
		&& out_o.mb_type == BSC_MBTYPE_DIRECT) else $error("off");
	chk_direct_skip: assert property (dir && !dco && !off && !nz && !mbaff_i
		|=> out_o.mb_skip_flag && out_o.coded_block_pattern == 6'h00) else $error("conv");
	chk_pair_top: assert property (top_skip |=> out_o.mb_skip_flag && out_o.pair_skip_permitted)
		else $error("top");
	chk_pair_bottom: assert property (top_skip ##1 (mb_valid_i && mb_i.skip_hint
		&& nbr_i.avail_a && mb_i.pair_field_flag != nbr_i.field_a)
		|=> !out_o.mb_skip_flag && !out_o.pair_skip_permitted) else $error("bottom");
endmodule : bsc_sva

/* File: tb/bsc_src.sv */
// upstream mode-decision source model
`timescale 1ns/10ps
module bsc_src
	import bsc_pkg::*;
(
	input	wire logic	clk_i,	// clock
	output	logic		valid_o,	// strobe
	output	bsc_mb_s	mb_o,	// macroblock
	output	logic [5:0]	cbp_o	// quantised cbp
);
	// quiet bus at time zero
	initial begin
		valid_o = 1'b0;
		mb_o = '0;
		cbp_o = 6'h00;
	end
	// one macroblock per edge, back to back allowed
	task automatic send(input bsc_mb_s m, input logic [5:0] c);
		@(posedge clk_i);
		valid_o <= 1'b1;
		mb_o <= m;
		cbp_o <= c;
	endtask : send
	// drop strobe, invert data so stale fields never look current
	task automatic idle;
		@(posedge clk_i);
		valid_o <= 1'b0;
		mb_o <= ~mb_o;
		cbp_o <= ~cbp_o;
	endtask : idle
endmodule : bsc_src

/* File: tb/testbench.sv */
// self-checking bench for the b-slice skip/direct converter
`timescale 1ns/10ps
module testbench;
	import bsc_pkg::*;
	logic		mclk_i = 1'b0;	// clock
	logic		nrst_i = 1'b0;	// reset, active low
	logic		ss = 1'b0;	// slice start
	logic		bs = 1'b1;	// b slice
	logic		ma = 1'b0;	// mbaff
	logic		sk = 1'b0;	// slice skip off
	logic		dc = 1'b0;	// slice direct off
	bsc_nbr_s	nbr = '0;	// neighbours
	logic		vld;	// strobe
	bsc_mb_s	mb;	// macroblock
	logic [5:0]	cq;	// quantised cbp
	logic		ov;	// decision pulse
	bsc_out_s	oo;	// decision
	int		failures = 0;	// mismatches
	int		check_count = 0;	// comparisons
	bsc_convert #(.CBP_W(6)) uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .slice_start_i(ss),
		.b_slice_i(bs), .mbaff_i(ma), .slice_skip_conversion_off_i(sk),
		.slice_direct_conversion_off_i(dc), .mb_valid_i(vld), .mb_i(mb), .nbr_i(nbr),
		.cbp_quant_i(cq), .mv_match_i(1'b0), .out_valid_o(ov), .out_o(oo));
	bsc_src src (.clk_i(mclk_i), .valid_o(vld), .mb_o(mb), .cbp_o(cq));
	// 250 mhz clock
	initial forever #2 mclk_i = ~mclk_i;
	// verdict and end of run
	task automatic wrap_up;
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// compare {pulse, skip flag, type, cbp, pair permission, sub-block coding}
	task automatic chk(input logic [14:0] e);
		logic [14:0] got;
		got = {ov, oo.mb_skip_flag, oo.mb_type, oo.coded_block_pattern, oo.pair_skip_permitted, oo.sub_individual};
		check_count++;
		if (got !== e) begin
			failures++;
			$display("Error decision exp %h got %h", e, got);
		end
	endtask : chk
	// f = {skip hint, 4x4 shape, per-block off, field flag}
	function automatic bsc_mb_s mk(logic [3:0] f, logic [5:0] ci);
		return '{f[3], BSC_MBTYPE_B8X8, BSC_DIRECT_ALL, {8{f[2]}}, ci, f[1], f[0]};
	endfunction : mk
	// single macroblock, k = {skip off, direct off}
	task automatic one(input bsc_mb_s m, input logic [5:0] c, input logic [1:0] k,
		input logic [14:0] e);
		@(posedge mclk_i);
		{sk, dc} <= k;
		src.send(m, c);
		src.idle;
		#1 chk(e);
	endtask : one
	// back-to-back top and bottom
	task automatic two(input bsc_mb_s t, input bsc_mb_s b, input logic [14:0] et,
		input logic [14:0] eb);
		src.send(t, 6'h3f);
		src.send(b, 6'h3f);
		#1 chk(et);
		src.idle;
		#1 chk(eb);
	endtask : two
	// mbaff slice start with slice type and neighbours
	task automatic start(input logic b, input bsc_nbr_s n);
		@(posedge mclk_i);
		ss <= 1'b1;
		bs <= b;
		ma <= 1'b1;
		nbr <= n;
		{sk, dc} <= 2'b00;
		@(posedge mclk_i);
		ss <= 1'b0;
	endtask : start
	// single macroblocks outside mbaff
	task automatic t_flat;
		one(mk(4'ha, 6'h3f), 6'h3f, 2'b10, 15'h6002);
		one(mk(4'h0, 6'h0f), 6'h30, 2'b00, 15'h6002);
		one(mk(4'h4, 6'h0f), 6'h00, 2'b10, 15'h4002);
		one(mk(4'h2, 6'h0f), 6'h00, 2'b00, 15'h4002);
		one(mk(4'h4, 6'h03), 6'h01, 2'b10, 15'h4006);
		one(mk(4'h0, 6'h3f), 6'h00, 2'b01, 15'h5603);
	endtask : t_flat
	// mbaff pairs: neighbour choice, stored top, slice clear
	task automatic t_pairs;
		start(1'b1, 4'hc);
		two(mk(4'h8, 6'h3f), mk(4'h8, 6'h3f), 15'h6002, 15'h4000);
		two(mk(4'h0, 6'h01), mk(4'h8, 6'h3f), 15'h4006, 15'h6002);
		start(1'b1, 4'h6);
		two(mk(4'h8, 6'h3f), mk(4'h8, 6'h3f), 15'h6002, 15'h6002);
		start(1'b1, 4'h0);
		two(mk(4'h9, 6'h3f), mk(4'h9, 6'h3f), 15'h6002, 15'h4000);
		one(mk(4'h8, 6'h3f), 6'h3f, 2'b00, 15'h6002);
		start(1'b1, 4'hc);
		two(mk(4'h8, 6'h3f), mk(4'h0, 6'h00), 15'h6002, 15'h4000);
		start(1'b0, 4'hc);
		two(mk(4'h8, 6'h3f), mk(4'h8, 6'h3f), 15'h6002, 15'h4000);
	endtask : t_pairs
	// reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		t_flat;
		t_pairs;
		wrap_up;
	end
endmodule : testbench
bind bsc_convert bsc_sva #(.CBP_W(CBP_W)) chk (.*);
